// ==== include/arpt_pkg.sv ====
// package of register offsets, field positions and reset values for the auto-reload pwm timer
package arpt_pkg;
	// register offsets (byte addresses within the timer window)
	localparam logic [3:0] ADDR_CTRL_STATUS = 4'h0;
	localparam logic [3:0] ADDR_COUNTER = 4'h1;
	localparam logic [3:0] ADDR_RELOAD = 4'h2;
	localparam logic [3:0] ADDR_PWM_CTRL = 4'h3;
	localparam logic [3:0] ADDR_DUTY0 = 4'h4;
	localparam logic [3:0] ADDR_DUTY1 = 4'h5;
	localparam logic [3:0] ADDR_DUTY2 = 4'h6;
	localparam logic [3:0] ADDR_DUTY3 = 4'h7;
	localparam logic [3:0] ADDR_CAP_CTRL = 4'h8;
	localparam logic [3:0] ADDR_CAP1 = 4'h9;
	localparam logic [3:0] ADDR_CAP2 = 4'hA;
	// control/status field positions
	localparam int CSR_EXT_CLK = 7;
	localparam int CSR_DIV_HI = 6;
	localparam int CSR_DIV_LO = 4;
	localparam int CSR_RUN = 3;
	localparam int CSR_FORCE = 2;
	localparam int CSR_OVF_IE = 1;
	localparam int CSR_OVF = 0;
	// pwm control field positions
	localparam int PWM_OE_LO = 4;
	localparam int PWM_POL_LO = 0;
	// capture control field positions
	localparam int CAP_EDGE_LO = 4;
	localparam int CAP_IE_LO = 2;
	localparam int CAP_FLAG_LO = 0;
	// reset value shared by the counter, reload, duty, capture and read data registers
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [6:0] PRESC_RESET = 7'h00;
	// synchroniser fill count: edges after reset before pin history is real
	localparam logic [1:0] SYNC_FILL = 2'h3;
endpackage : arpt_pkg

// ==== design/arpt_timer.sv ====
// auto-reload pwm timer: prescaler, 8-bit counter, four pwm channels, two capture channels
`timescale 1ns/1ps
module arpt_timer
	import arpt_pkg::*;
#(
	parameter int NUM_PWM = 4,
	parameter int NUM_CAP = 2
)
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic halt_mode,
	input wire logic external_input_clock,
	input wire logic [NUM_CAP-1:0] capture_input_pin,
	output logic [NUM_PWM-1:0] pwm_output_pin,
	output logic [NUM_PWM-1:0] pwm_output_oe,
	output logic overflow_irq,
	output logic [NUM_CAP-1:0] capture_irq,
	output logic wakeup
);

	// software-visible state
	logic external_clock_select_r;
	logic [2:0] clock_divide_select_r;
	logic counter_run_enable_r;
	logic overflow_irq_enable_r;
	logic overflow_flag_r;
	logic [7:0] auto_reload_value_r;
	logic [NUM_PWM-1:0] channel_output_enable_r;
	logic [NUM_PWM-1:0] channel_polarity_r;
	logic [7:0] duty_cycle_value_r [NUM_PWM];
	logic [NUM_CAP-1:0] capture_edge_select_r;
	logic [NUM_CAP-1:0] capture_irq_enable_r;
	logic [NUM_CAP-1:0] capture_flag_r;
	logic [7:0] capture_value_r [NUM_CAP];

	// timer core state
	logic [6:0] presc_r;
	logic [7:0] count_r;
	logic [7:0] compare_value_r [NUM_PWM];
	logic [NUM_PWM-1:0] pwm_level_r;

	// input synchronisers and edge history
	logic ext_meta_r;
	logic ext_sync_r;
	logic ext_prev_r;
	logic [NUM_CAP-1:0] cap_meta_r;
	logic [NUM_CAP-1:0] cap_sync_r;
	logic [NUM_CAP-1:0] cap_prev_r;
	logic [1:0] sync_fill_r;
	logic sync_ready;

	logic wr_csr;
	logic wr_cnt;
	logic rd_csr;
	logic force_reload;
	logic regs_frozen;
	logic src_pulse;
	logic presc_en;
	logic tick;
	logic overflow;
	logic [NUM_CAP-1:0] cap_edge;
	logic [NUM_CAP-1:0] cap_rd;

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ext_meta_r <= 1'b0;
			ext_sync_r <= 1'b0;
			ext_prev_r <= 1'b0;
			cap_meta_r <= '0;
			cap_sync_r <= '0;
			cap_prev_r <= '0;
			sync_fill_r <= 2'h0;
		end
		else
		begin
			ext_meta_r <= external_input_clock;
			ext_sync_r <= ext_meta_r;
			ext_prev_r <= ext_sync_r;
			cap_meta_r <= capture_input_pin;
			cap_sync_r <= cap_meta_r;
			cap_prev_r <= cap_sync_r;
			if (sync_fill_r != SYNC_FILL)
				sync_fill_r <= sync_fill_r + 2'h1;
		end
	end

	// reset history may differ from a pin's idle level, so edges wait until the chain holds real levels
	assign sync_ready = (sync_fill_r == SYNC_FILL);

	// halt with external clock freezes the control registers
	assign regs_frozen = halt_mode && external_clock_select_r;
	assign wr_csr = reg_wr && !regs_frozen && (reg_addr == ADDR_CTRL_STATUS);
	assign wr_cnt = reg_wr && !regs_frozen && (reg_addr == ADDR_COUNTER);
	assign rd_csr = reg_rd && (reg_addr == ADDR_CTRL_STATUS);
	// force reload acts only as a written one
	assign force_reload = wr_csr && reg_wdata[CSR_FORCE];

	// input clock source, external edge is one event
	assign src_pulse = external_clock_select_r ? (sync_ready && ext_sync_r && !ext_prev_r) : 1'b1;
	// run enable gates the prescaler; cpu source stops in halt
	assign presc_en = counter_run_enable_r && src_pulse && (external_clock_select_r || !halt_mode);

	// tick when all bits below the selected tap are ones
	function automatic logic tap_hit(input logic [6:0] p, input logic [2:0] sel);
		logic [6:0] mask;
		mask = 7'(8'h01 << sel) - 7'h01;
		return (p & mask) == mask;
	endfunction : tap_hit

	assign tick = presc_en && tap_hit(presc_r, clock_divide_select_r);
	assign overflow = tick && (count_r == 8'hFF);

	// 7-bit prescaler, cleared by reload or counter write
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			presc_r <= PRESC_RESET;
		else if (force_reload || wr_cnt)
			presc_r <= PRESC_RESET;
		else if (presc_en)
			presc_r <= tick ? PRESC_RESET : presc_r + 7'h01;
	end

	// counter, write on the fly, reload on overflow
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			count_r <= REG_RESET;
		else if (wr_cnt)
			count_r <= reg_wdata;
		else if (force_reload)
			count_r <= auto_reload_value_r;
		else if (overflow)
			count_r <= auto_reload_value_r;
		else if (tick)
			count_r <= count_r + 8'h01;
	end

	// control register, reset selects the cpu clock
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			external_clock_select_r <= 1'b0;
			clock_divide_select_r <= 3'h0;
			counter_run_enable_r <= 1'b0;
			overflow_irq_enable_r <= 1'b0;
		end
		else if (wr_csr)
		begin
			external_clock_select_r <= reg_wdata[CSR_EXT_CLK];
			clock_divide_select_r <= reg_wdata[CSR_DIV_HI:CSR_DIV_LO];
			counter_run_enable_r <= reg_wdata[CSR_RUN];
			overflow_irq_enable_r <= reg_wdata[CSR_OVF_IE];
		end
	end

	// sticky overflow flag, set wins over the read clear
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			overflow_flag_r <= 1'b0;
		else if (overflow)
			overflow_flag_r <= 1'b1;
		else if (rd_csr)
			overflow_flag_r <= 1'b0;
	end

	// software-written configuration registers
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			auto_reload_value_r <= REG_RESET;
			channel_output_enable_r <= '0;
			channel_polarity_r <= '0;
			capture_edge_select_r <= '0;
			capture_irq_enable_r <= '0;
			for (int i = 0; i < NUM_PWM; i++)
				duty_cycle_value_r[i] <= REG_RESET;
		end
		else if (reg_wr && !regs_frozen)
		begin
			unique case (reg_addr)
				ADDR_RELOAD: auto_reload_value_r <= reg_wdata;
				ADDR_PWM_CTRL:
				begin
					channel_output_enable_r <= reg_wdata[PWM_OE_LO +: NUM_PWM];
					channel_polarity_r <= reg_wdata[PWM_POL_LO +: NUM_PWM];
				end
				ADDR_DUTY0: duty_cycle_value_r[0] <= reg_wdata;
				ADDR_DUTY1: duty_cycle_value_r[1] <= reg_wdata;
				ADDR_DUTY2: duty_cycle_value_r[2] <= reg_wdata;
				ADDR_DUTY3: duty_cycle_value_r[3] <= reg_wdata;
				ADDR_CAP_CTRL:
				begin
					capture_edge_select_r <= reg_wdata[CAP_EDGE_LO +: NUM_CAP];
					capture_irq_enable_r <= reg_wdata[CAP_IE_LO +: NUM_CAP];
				end
				default: ;
			endcase
		end
	end

	// compare values double-buffered, copied at overflow
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			for (int i = 0; i < NUM_PWM; i++)
				compare_value_r[i] <= REG_RESET;
		end
		else if (overflow)
		begin
			for (int i = 0; i < NUM_PWM; i++)
				compare_value_r[i] <= duty_cycle_value_r[i];
		end
	end

	// pwm raw level: set at overflow, cleared at compare match
	// period runs reload..FF so 256 minus reload ticks
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			pwm_level_r <= '0;
		else if (!halt_mode)
		begin
			for (int i = 0; i < NUM_PWM; i++)
			begin
				if (overflow)
					pwm_level_r[i] <= 1'b1;
				// match restores; never reached if compare < reload
				else if (tick && (count_r == compare_value_r[i]))
					pwm_level_r[i] <= 1'b0;
			end
		end
	end

	// polarity inverts at once; drive only enabled pins
	always_comb
	begin
		pwm_output_pin = (pwm_level_r ^ channel_polarity_r) & channel_output_enable_r;
		pwm_output_oe = channel_output_enable_r;
	end

	// capture read strobes per channel
	assign cap_rd[0] = reg_rd && (reg_addr == ADDR_CAP1);
	assign cap_rd[1] = reg_rd && (reg_addr == ADDR_CAP2);

	always_comb
	begin
		for (int i = 0; i < NUM_CAP; i++)
			cap_edge[i] = sync_ready && (capture_edge_select_r[i] ? (cap_sync_r[i] && !cap_prev_r[i])
				: (!cap_sync_r[i] && cap_prev_r[i]));
	end

	// capture on edge; blocked while flag set, read clears
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			capture_flag_r <= '0;
			for (int i = 0; i < NUM_CAP; i++)
				capture_value_r[i] <= REG_RESET;
		end
		else
		begin
			for (int i = 0; i < NUM_CAP; i++)
			begin
				// a new edge in the read cycle wins and keeps the flag
				if (cap_edge[i] && (!capture_flag_r[i] || cap_rd[i]))
				begin
					capture_value_r[i] <= count_r;
					capture_flag_r[i] <= 1'b1;
				end
				else if (cap_rd[i])
					capture_flag_r[i] <= 1'b0;
			end
		end
	end

	assign overflow_irq = overflow_flag_r && overflow_irq_enable_r;
	assign capture_irq = capture_flag_r & capture_irq_enable_r;

	// wake from halt on enabled overflow or capture edge
	assign wakeup = halt_mode && ((overflow && overflow_irq_enable_r) || |(cap_edge & capture_irq_enable_r));

	// read data, one cycle after the strobe
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			reg_rdata <= REG_RESET;
		else if (reg_rd)
		begin
			unique case (reg_addr)
				ADDR_CTRL_STATUS: reg_rdata <= {external_clock_select_r, clock_divide_select_r,
					counter_run_enable_r, 1'b0, overflow_irq_enable_r, overflow_flag_r};
				ADDR_COUNTER: reg_rdata <= count_r;
				ADDR_RELOAD: reg_rdata <= auto_reload_value_r;
				ADDR_PWM_CTRL: reg_rdata <= {channel_output_enable_r, channel_polarity_r};
				ADDR_DUTY0: reg_rdata <= duty_cycle_value_r[0];
				ADDR_DUTY1: reg_rdata <= duty_cycle_value_r[1];
				ADDR_DUTY2: reg_rdata <= duty_cycle_value_r[2];
				ADDR_DUTY3: reg_rdata <= duty_cycle_value_r[3];
				ADDR_CAP_CTRL: reg_rdata <= {2'b00, capture_edge_select_r, capture_irq_enable_r, capture_flag_r};
				ADDR_CAP1: reg_rdata <= capture_value_r[0];
				ADDR_CAP2: reg_rdata <= capture_value_r[1];
				default: reg_rdata <= REG_RESET;
			endcase
		end
	end

endmodule : arpt_timer

// ==== dv/arpt_timer_chk.sv ====
// concurrent checks on the timer ports
`timescale 1ns/1ps
module arpt_timer_chk
	import arpt_pkg::*;
#(
	parameter int NUM_PWM = 4,
	parameter int NUM_CAP = 2
)
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic halt_mode,
	input wire logic external_input_clock,
	input wire logic [NUM_CAP-1:0] capture_input_pin,
	input wire logic [NUM_PWM-1:0] pwm_output_pin,
	input wire logic [NUM_PWM-1:0] pwm_output_oe,
	input wire logic overflow_irq,
	input wire logic [NUM_CAP-1:0] capture_irq,
	input wire logic wakeup
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	a_oe_follows: assert property (reg_wr && !halt_mode && reg_addr == ADDR_PWM_CTRL |=>
		pwm_output_oe == NUM_PWM'($past(reg_wdata) >> 4)) else $error("pwm enables differ from write");
	a_off_low: assert property ((pwm_output_pin & ~pwm_output_oe) == '0)
		else $error("disabled pwm pin driven high");
	a_rw_readback: assert property ((reg_wr && !halt_mode && reg_addr >= ADDR_RELOAD && reg_addr <= ADDR_DUTY3)
		##1 (reg_rd && reg_addr == $past(reg_addr)) |=> reg_rdata == $past(reg_wdata, 2))
		else $error("register read back differs from write");
	a_force_rd: assert property (reg_rd && reg_addr == ADDR_CTRL_STATUS |=> !reg_rdata[CSR_FORCE])
		else $error("force reload bit read as one");
	a_cap_irq: assert property (reg_rd && reg_addr == ADDR_CAP_CTRL |=> reg_rdata[7:6] == 2'b00 &&
		NUM_CAP'(reg_rdata[3:2] & reg_rdata[1:0]) == $past(capture_irq)) else $error("capture request mismatch");
	a_ovf_irq: assert property (reg_rd && reg_addr == ADDR_CTRL_STATUS |=>
		(reg_rdata[CSR_OVF_IE] && reg_rdata[CSR_OVF]) == $past(overflow_irq)) else $error("overflow request mismatch");
	a_wake_halt: assert property (wakeup |-> halt_mode)
		else $error("wakeup outside halt");
	a_wake_irq: assert property (wakeup && !reg_wr |=> overflow_irq || capture_irq != '0)
		else $error("wakeup without a pending request");
	a_halt_freeze: assert property (halt_mode && $past(halt_mode) && !$past(reg_wr) |-> $stable(pwm_output_pin))
		else $error("pwm pin moved during halt");
endmodule : arpt_timer_chk

bind arpt_timer arpt_timer_chk #(.NUM_PWM(NUM_PWM), .NUM_CAP(NUM_CAP)) u_chk (.ref_clk(ref_clk), .rst_n(rst_n),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.halt_mode(halt_mode), .external_input_clock(external_input_clock), .capture_input_pin(capture_input_pin),
	.pwm_output_pin(pwm_output_pin), .pwm_output_oe(pwm_output_oe), .overflow_irq(overflow_irq),
	.capture_irq(capture_irq), .wakeup(wakeup));

// ==== dv/arpt_pins.sv ====
// pin-side model: external event clock and capture inputs
`timescale 1ns/1ps
module arpt_pins
(
	output logic external_input_clock,
	output logic [1:0] capture_input_pin
);
	initial
	begin
		external_input_clock = 1'b0;
		capture_input_pin = 2'b10;
	end
	// event pulses of w cycles per level, off the timer clock phase
	task automatic pulses(input int n, input int w);
		repeat (n)
		begin
			#(w * 20 + 3) external_input_clock = 1'b1;
			#(w * 20 - 3) external_input_clock = 1'b0;
		end
	endtask : pulses
	// capture levels change asynchronously; the caller is not held up
	task automatic cap(input logic [1:0] v);
		capture_input_pin <= #7 v;
	endtask : cap
endmodule : arpt_pins

// ==== dv/auto_reload_pwm_timer_test.sv ====
// self-checking bench for the auto-reload pwm timer
`timescale 1ns/1ps
module auto_reload_pwm_timer_test
	import arpt_pkg::*;
;
	logic ref_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, halt_mode = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00, reg_rdata, v;
	logic [3:0] pwm_output_pin, pwm_output_oe;
	logic [1:0] capture_input_pin, capture_irq;
	logic external_input_clock, overflow_irq, wakeup, rd_seen = 1'b0, wake_seen = 1'b0, pin_look = 1'b0;
	logic [1:0] look_sel = 2'h0;
	logic [7:0] seen;
	logic [15:0] note, exp_q[$];
	int miscompares = 0, samples_checked = 0;
	always #10 ref_clk = ~ref_clk;
	arpt_timer u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .halt_mode(halt_mode),
		.external_input_clock(external_input_clock), .capture_input_pin(capture_input_pin),
		.pwm_output_pin(pwm_output_pin), .pwm_output_oe(pwm_output_oe), .overflow_irq(overflow_irq),
		.capture_irq(capture_irq), .wakeup(wakeup));
	arpt_pins u_pins (.external_input_clock(external_input_clock), .capture_input_pin(capture_input_pin));
	task automatic chk(input logic [7:0] seen, input logic [7:0] want);
		samples_checked++;
		if (seen !== want)
		begin
			miscompares++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask : chk
	task automatic wrap_up;
		$display("checked %0d, mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : wrap_up
	// one bus cycle; signals stay until the next call, so strobes never pulse twice in a step
	task automatic bus(input logic w, input logic r, input logic [3:0] a, input logic [7:0] d);
		reg_wr <= w;
		reg_rd <= r;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
	endtask : bus
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		bus(1'b1, 1'b0, a, d);
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m = 8'hFF);
		exp_q.push_back({m, e});
		bus(1'b0, 1'b1, a, 8'h00);
	endtask : rd
	task automatic idle(input int n);
		repeat (n) bus(1'b0, 1'b0, 4'h0, 8'h00);
	endtask : idle
	// one idle cycle whose closing edge compares a group: 0 pwm pins, 1 wake latch, 2 requests
	task automatic look(input logic [1:0] s, input logic [7:0] e);
		exp_q.push_back({8'hFF, e});
		pin_look <= 1'b1;
		look_sel <= s;
		bus(1'b0, 1'b0, 4'h0, 8'h00);
		pin_look <= 1'b0;
	endtask : look
	// read data stands one cycle after the strobe; compare with the oldest note
	always @(posedge ref_clk)
	begin
		if (rd_seen)
		begin
			note = exp_q.pop_front();
			chk(reg_rdata & note[15:8], note[7:0]);
		end
		// levels settled before this edge, in the order they were noted
		if (pin_look)
		begin
			note = exp_q.pop_front();
			if (look_sel == 2'h0)
				seen = {pwm_output_oe, pwm_output_pin};
			else if (look_sel == 2'h1)
				seen = 8'(wake_seen);
			else
				seen = {5'h00, overflow_irq, capture_irq};
			chk(seen & note[15:8], note[7:0]);
		end
		rd_seen <= reg_rd;
		if (wakeup)
			wake_seen <= 1'b1;
	end
	// a hang ends the run as a failure
	initial
	begin
		repeat (20000) @(posedge ref_clk);
		miscompares++;
		wrap_up();
	end
	initial
	begin
		v = 8'($urandom(32'h5719));
		repeat (3) @(posedge ref_clk);
		rst_n <= 1'b1;
		for (int a = 0; a < 16; a++) rd(4'(a), 8'h00);
		// random values written and read back
		for (int a = ADDR_RELOAD; a <= ADDR_CAP_CTRL; a++)
		begin
			v = 8'($urandom);
			wr(4'(a), v);
			rd(4'(a), (a == ADDR_CAP_CTRL) ? (v & 8'h3C) : v);
		end
		// stopped counter holds a written value
		wr(ADDR_CTRL_STATUS, 8'h00);
		wr(ADDR_COUNTER, v);
		idle(20);
		rd(ADDR_COUNTER, v);
		// every tap: sixteen ticks in sixteen prescaler periods
		for (int n = 0; n < 8; n++)
		begin
			v = 8'($urandom) & 8'h7F;
			wr(ADDR_CTRL_STATUS, 8'(n << 4) | 8'h08);
			wr(ADDR_COUNTER, v);
			idle(16 * (1 << n) + (1 << n) / 2 - 1);
			wr(ADDR_CTRL_STATUS, 8'(n << 4));
			rd(ADDR_COUNTER, v + 8'h10);
		end
		// wrap to reload, pin levels after overflow
		wr(ADDR_RELOAD, 8'hF0);
		wr(ADDR_DUTY0, 8'hF8);
		wr(ADDR_DUTY1, 8'hE0);
		wr(ADDR_PWM_CTRL, 8'h32);
		wr(ADDR_CTRL_STATUS, 8'h0A);
		wr(ADDR_COUNTER, 8'hFE);
		idle(6);
		wr(ADDR_CTRL_STATUS, 8'h02);
		look(2'h0, 8'h31);
		rd(ADDR_COUNTER, 8'hF5);
		look(2'h2, 8'h04);
		rd(ADDR_CTRL_STATUS, 8'h03);
		rd(ADDR_CTRL_STATUS, 8'h02);
		wr(ADDR_PWM_CTRL, 8'h31);
		look(2'h0, 8'h32);
		// compare passed: channel 0 restored, channel 1 never
		wr(ADDR_CTRL_STATUS, 8'h0A);
		idle(4);
		wr(ADDR_CTRL_STATUS, 8'h02);
		look(2'h0, 8'h33);
		wr(ADDR_CTRL_STATUS, 8'h06);
		rd(ADDR_COUNTER, 8'hF0);
		rd(ADDR_CTRL_STATUS, 8'h02);
		// one full period from reload F0 is sixteen ticks back to F0
		wr(ADDR_CTRL_STATUS, 8'h0A);
		idle(15);
		wr(ADDR_CTRL_STATUS, 8'h02);
		rd(ADDR_COUNTER, 8'hF0);
		rd(ADDR_CTRL_STATUS, 8'h03);
		// capture on selected edges, then blocked until read
		wr(ADDR_CAP_CTRL, 8'h1C);
		idle(1);
		u_pins.cap(2'b01);
		idle(6);
		look(2'h2, 8'h03);
		rd(ADDR_CAP_CTRL, 8'h1F);
		wr(ADDR_COUNTER, 8'h33);
		idle(1);
		u_pins.cap(2'b10);
		idle(6);
		u_pins.cap(2'b01);
		idle(6);
		rd(ADDR_CAP1, 8'hF0);
		rd(ADDR_CAP_CTRL, 8'h1E);
		u_pins.cap(2'b10);
		idle(6);
		rd(ADDR_CAP_CTRL, 8'h1E);
		rd(ADDR_CAP2, 8'hF0);
		u_pins.cap(2'b01);
		idle(6);
		rd(ADDR_CAP1, 8'h33);
		rd(ADDR_CAP2, 8'h33);
		// external events, fast then slow with a divide by two
		wr(ADDR_COUNTER, 8'h40);
		wr(ADDR_CTRL_STATUS, 8'h88);
		fork
			u_pins.pulses(5, 2);
			idle(32);
		join
		rd(ADDR_COUNTER, 8'h45);
		wr(ADDR_CTRL_STATUS, 8'h98);
		wr(ADDR_COUNTER, 8'h40);
		fork
			u_pins.pulses(6, 5);
			idle(70);
		join
		rd(ADDR_COUNTER, 8'h43);
		// halt on external clock: writes frozen, overflow wakes
		wr(ADDR_CTRL_STATUS, 8'h8A);
		wr(ADDR_COUNTER, 8'hFE);
		halt_mode <= 1'b1;
		wr(ADDR_RELOAD, 8'h77);
		fork
			u_pins.pulses(2, 3);
			idle(20);
		join
		halt_mode <= 1'b0;
		rd(ADDR_RELOAD, 8'hF0);
		rd(ADDR_CTRL_STATUS, 8'h8B);
		look(2'h1, 8'h01);
		idle(2);
		wrap_up();
	end
endmodule : auto_reload_pwm_timer_test
